// ---- rtl/wwdt_presc.sv ----
// windowed watchdog timer: divides oscillator edges down to the watchdog tick
`timescale 1ns/100ps
module wwdt_presc
    import wwdt_pkg::*;
#(
    parameter int DIV = OSC_DIV
)
(
    // clock and reset
    input  wire logic mclk_in,
    input  wire logic rstn_in,
    // oscillator edge pulse in, tick pulse out
    input  wire logic edge_in,
    output logic      tick_out
);

    localparam int DW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [DW-1:0] LAST = DW'(DIV - 1);

    logic [DW-1:0] cnt_q;
    logic          tick_q;

    // one tick per DIV oscillator edges
    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in)
        begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= edge_in && (cnt_q == LAST);
            if (edge_in)
                cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + DW'(1);
        end
    end

    assign tick_out = tick_q;

    a_tick_single: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        tick_q |=> !tick_q)
        else $error("watchdog tick longer than one cycle");

endmodule // wwdt_presc

// ---- rtl/wwdt_sync.sv ----
// windowed watchdog timer: three-stage pin synchroniser with rising-edge pulse
`timescale 1ns/100ps
module wwdt_sync
    import wwdt_pkg::*;
(
    // clock and reset
    input  wire logic mclk_in,
    input  wire logic rstn_in,
    // asynchronous level and its qualified rising edge
    input  wire logic async_in,
    output logic      rise_out
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    logic rise_q;

    // the first stage feeds only the second; a change counts when stages two and three agree
    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in)
        begin
            s1_q   <= 1'b1;
            s2_q   <= 1'b1;
            s3_q   <= 1'b1;
            lvl_q  <= 1'b1; // start high: a pin already high at release gives no false edge
            rise_q <= 1'b0;
        end
        else
        begin
            s1_q   <= async_in;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            if (s2_q == s3_q)
                lvl_q <= s3_q;
            rise_q <= (s2_q == s3_q) && s3_q && !lvl_q;
        end
    end

    assign rise_out = rise_q;

    a_rise_agreed: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        rise_q |-> lvl_q && !$past(lvl_q))
        else $error("edge pulse without a settled rising level");

endmodule // wwdt_sync

// ---- rtl/wwdt_top.sv ----
// windowed watchdog timer: registers, unlock guard, crossings and timeout engine
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/100ps
module wwdt_top
    import wwdt_pkg::*;
#(
    parameter int OSC_EDGES_PER_TICK = OSC_DIV
)
(
    // clock and reset
    input  wire logic              mclk_in,
    input  wire logic              rstn_in,
    // slow oscillator, asynchronous to mclk_in
    input  wire logic              ultra_low_power_osc_in,
    // register port
    input  wire logic [REG_AW-1:0] reg_addr_in,
    input  wire logic [REG_DW-1:0] reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic      [REG_DW-1:0] reg_rdata_out,
    // processor core
    input  wire logic              watchdog_clear_instruction_in,
    input  wire logic              config_change_guard_in,
    // boot configuration
    input  wire logic [REG_DW-1:0] fuse_ctrl_in,
    // system reset controller
    output logic                   reset_req_out
);

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rstn_in);

    logic              osc_rise;
    logic              watchdog_tick_clock;
    logic              boot_q;
    logic [2:0]        guard_q;
    logic              guard_open;
    logic              wr_ctrl;
    logic              wr_status;
    logic              cfg_accept;
    logic              cfg_pend_q;
    logic [1:0]        cfg_ticks_q;
    logic              cfg_apply;
    wwdt_ctrl_t        shadow_q;
    wwdt_ctrl_t        ctrl_q;
    wwdt_ctrl_t        fuse_cfg;
    logic              lock_q;
    logic              clr_pend_q;
    logic [1:0]        clr_ticks_q;
    logic              clr_apply;
    wwdt_state_t       state_q;
    logic [CNT_W-1:0]  cnt_q;
    logic [CNT_W-1:0]  open_last;
    logic [CNT_W-1:0]  closed_last;
    logic              open_phase;
    logic              expire;
    logic              reset_req_d;
    logic              reset_req_q;
    logic [REG_DW-1:0] rdata_d;
    logic [REG_DW-1:0] rdata_q;
    wwdt_status_t      status;

    // oscillator pin crossing, then division to the watchdog tick
    wwdt_sync u_sync (
        .mclk_in  (mclk_in),
        .rstn_in  (rstn_in),
        .async_in (ultra_low_power_osc_in),
        .rise_out (osc_rise)
    );

    wwdt_presc #(
        .DIV      (OSC_EDGES_PER_TICK)
    ) u_presc (
        .mclk_in  (mclk_in),
        .rstn_in  (rstn_in),
        .edge_in  (osc_rise),
        .tick_out (watchdog_tick_clock)
    );

    assign fuse_cfg = wwdt_ctrl_t'(fuse_ctrl_in);

    // first cycle after release loads the fuse configuration
    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in)
            boot_q <= 1'b0;
        else
            boot_q <= 1'b1;
    end

    // unlock window: the guard key opens a short slot for protected writes
    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in)
            guard_q <= '0;
        else if (config_change_guard_in)
            guard_q <= GUARD_CYCLES;
        else if (guard_q != '0)
            guard_q <= guard_q - 3'h1;
    end

    assign guard_open = (guard_q != '0);
    assign wr_ctrl    = reg_wr_in && (reg_addr_in == REG_CTRL_ADDR);
    assign wr_status  = reg_wr_in && (reg_addr_in == REG_STATUS_ADDR);
    // writes while a crossing is busy are dropped, as are unguarded or locked ones
    assign cfg_accept = wr_ctrl && guard_open && !lock_q && !cfg_pend_q;

    // control write crossing into the tick domain
    assign cfg_apply = cfg_pend_q && watchdog_tick_clock
                       && (cfg_ticks_q == SYNC_TICKS_LAST);

    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in)
        begin
            cfg_pend_q  <= 1'b0;
            cfg_ticks_q <= '0;
            shadow_q    <= '0;
        end
        else if (cfg_accept)
        begin
            cfg_pend_q  <= 1'b1;
            cfg_ticks_q <= '0;
            shadow_q    <= wwdt_ctrl_t'(reg_wdata_in);
        end
        else if (cfg_apply)
            cfg_pend_q  <= 1'b0;
        else if (cfg_pend_q && watchdog_tick_clock)
            cfg_ticks_q <= cfg_ticks_q + 2'h1;
    end

    // control register: fuse value at boot, then only synchronised writes
    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in)
            ctrl_q <= '0;
        else if (!boot_q)
            ctrl_q <= fuse_cfg;
        else if (cfg_apply)
            ctrl_q <= shadow_q;
    end

    // lock: set-only; no software path clears it
    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in)
            lock_q <= 1'b0;
        else if (!boot_q)
            lock_q <= (fuse_cfg.period != CODE_OFF);
        else if (wr_status && guard_open && reg_wdata_in[LOCK_BIT])
            lock_q <= 1'b1;
    end

    // clear instruction crossing; a repeat during the crossing is ignored
    assign clr_apply = clr_pend_q && watchdog_tick_clock
                       && (clr_ticks_q == SYNC_TICKS_LAST);

    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in)
        begin
            clr_pend_q  <= 1'b0;
            clr_ticks_q <= '0;
        end
        else if (clr_apply)
            clr_pend_q  <= 1'b0;
        else if (watchdog_clear_instruction_in && !clr_pend_q)
        begin
            clr_pend_q  <= 1'b1;
            clr_ticks_q <= '0;
        end
        else if (clr_pend_q && watchdog_tick_clock)
            clr_ticks_q <= clr_ticks_q + 2'h1;
    end

    // period limits from the control selections
    assign open_last   = wwdt_limit(ctrl_q.period) - CNT_W'(1);
    assign closed_last = wwdt_limit(ctrl_q.window) - CNT_W'(1);
    assign open_phase  = (state_q == WD_NORMAL) || (state_q == WD_ARMED)
                         || (state_q == WD_OPEN);
    assign expire      = watchdog_tick_clock && (cnt_q == open_last);

    // reset request: late expiry in any open phase, or a clear in the closed phase
    always_comb
    begin
        reset_req_d = 1'b0;
        if (boot_q && !cfg_apply)
        begin
            if (open_phase && !clr_apply && expire)
                reset_req_d = 1'b1;
            else if ((state_q == WD_CLOSED) && clr_apply)
                reset_req_d = 1'b1;
        end
    end

    // timeout engine; nothing here looks at sleep, so counting goes on in every sleep state
    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in)
        begin
            state_q <= WD_OFF;
            cnt_q   <= '0;
        end
        else if (!boot_q)
        begin
            state_q <= wwdt_entry(fuse_cfg);
            cnt_q   <= '0;
        end
        else if (cfg_apply)
        begin
            state_q <= wwdt_entry(shadow_q);
            cnt_q   <= '0;
        end
        else
        begin
            case (state_q)
                WD_OFF:
                    cnt_q <= '0;
                WD_NORMAL, WD_ARMED, WD_OPEN:
                begin
                    if (clr_apply)
                    begin
                        // the first clear in window mode starts the closed period
                        state_q <= (ctrl_q.window != CODE_OFF) ? WD_CLOSED : WD_NORMAL;
                        cnt_q   <= '0;
                    end
                    else if (expire)
                    begin
                        state_q <= wwdt_entry(ctrl_q);
                        cnt_q   <= '0;
                    end
                    else if (watchdog_tick_clock)
                        cnt_q <= cnt_q + CNT_W'(1);
                end
                WD_CLOSED:
                begin
                    if (clr_apply)
                    begin
                        state_q <= wwdt_entry(ctrl_q);
                        cnt_q   <= '0;
                    end
                    else if (watchdog_tick_clock && (cnt_q == closed_last))
                    begin
                        state_q <= WD_OPEN;
                        cnt_q   <= '0;
                    end
                    else if (watchdog_tick_clock)
                        cnt_q <= cnt_q + CNT_W'(1);
                end
                default:
                begin
                    state_q <= WD_OFF;
                    cnt_q   <= '0;
                end
            endcase
        end
    end

    // one-cycle request toward the reset controller
    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in)
            reset_req_q <= 1'b0;
        else
            reset_req_q <= reset_req_d;
    end

    assign reset_req_out = reset_req_q;

    // read data stand only in the cycle after the strobe; unmapped offsets read zero
    assign status = '{lock: lock_q, zero: '0, clr_pending: clr_pend_q,
                      sync_pending: cfg_pend_q};

    always_comb
    begin
        rdata_d = '0;
        if (reg_rd_in)
        begin
            case (reg_addr_in)
                REG_CTRL_ADDR:   rdata_d = ctrl_q;
                REG_STATUS_ADDR: rdata_d = status;
                default:         rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in)
            rdata_q <= '0;
        else
            rdata_q <= rdata_d;
    end

    assign reg_rdata_out = rdata_q;

    // checks on the timeout engine, the crossings, the unlock guard and the lock
    sequence s_late_expiry;
        boot_q && !cfg_apply && open_phase && !clr_apply && expire;
    endsequence
    sequence s_closed_clear;
        boot_q && !cfg_apply && (state_q == WD_CLOSED) && clr_apply;
    endsequence
    sequence s_single_pulse;
        reset_req_q ##1 !reset_req_q;
    endsequence

    a_timeout_reset: assert property (
        s_late_expiry |=> reset_req_q && (cnt_q == '0))
        else $error("expiry did not raise a reset request");
    a_period_quiet: assert property (
        open_phase && watchdog_tick_clock && !clr_apply && (cnt_q < open_last)
        |=> !reset_req_q)
        else $error("reset request before the selected period ended");
    a_early_clear: assert property (
        s_closed_clear |=> s_single_pulse)
        else $error("clear in closed period did not give one reset request");
    a_first_clear: assert property (
        boot_q && !cfg_apply && (state_q == WD_ARMED) && clr_apply
        |=> (state_q == WD_CLOSED) && (cnt_q == '0))
        else $error("first clear did not start the closed period");
    a_clear_ignored: assert property (
        clr_pend_q && watchdog_clear_instruction_in && !watchdog_tick_clock
        |=> clr_pend_q && $stable(clr_ticks_q))
        else $error("clear during crossing was not ignored");
    a_guard_needed: assert property (
        wr_ctrl && !guard_open && !cfg_pend_q |=> !cfg_pend_q)
        else $error("unguarded control write was taken");
    a_lock_frozen: assert property (
        boot_q && lock_q && !cfg_pend_q |=> $stable(ctrl_q) && !cfg_pend_q && lock_q)
        else $error("locked configuration changed");
    a_write_synced: assert property (
        $rose(cfg_pend_q) |=> $stable(ctrl_q) [*2])
        else $error("control write took effect without crossing");
    a_enable_select: assert property (
        cfg_apply |=> ((state_q == WD_OFF) == (ctrl_q.period == CODE_OFF)))
        else $error("enable does not follow the period selection");
    a_window_select: assert property (
        cfg_apply && (shadow_q.period != CODE_OFF) && (shadow_q.window != CODE_OFF)
        |=> state_q == WD_ARMED)
        else $error("window selection did not arm window mode");
    a_off_silent: assert property (
        boot_q && (state_q == WD_OFF) |=> !reset_req_q)
        else $error("disabled watchdog requested reset");
    a_single_request: assert property (
        reset_req_q |=> !reset_req_q)
        else $error("reset request longer than one cycle");

endmodule // wwdt_top

// ---- shared/wwdt_pkg.sv ----
// windowed watchdog timer: register map, field layouts, timing constants and helpers
package wwdt_pkg;

    // register map, byte offsets on the plain register port
    localparam int          REG_AW          = 8;
    localparam int          REG_DW          = 8;
    localparam logic [7:0]  REG_CTRL_ADDR   = 8'h00;
    localparam logic [7:0]  REG_STATUS_ADDR = 8'h01;
    localparam int          LOCK_BIT        = 7;

    // tick counter and timeout selection
    localparam int          CNT_W           = 14;
    localparam logic [3:0]  CODE_OFF        = 4'h0;
    localparam logic [3:0]  CODE_MAX        = 4'hB;
    localparam logic [3:0]  TICK_SHIFT      = 4'h2;

    // oscillator edges per watchdog tick (32 kHz down to 1 kHz)
    localparam int          OSC_DIV         = 32;

    // unlock window length in system clocks after the guard key
    localparam logic [2:0]  GUARD_CYCLES    = 3'h4;

    // a crossing completes on the third tick after it is taken
    localparam logic [1:0]  SYNC_TICKS_LAST = 2'h2;

    // control register layout
    typedef struct packed {
        logic [3:0] window;
        logic [3:0] period;
    } wwdt_ctrl_t;

    // status register layout
    typedef struct packed {
        logic       lock;
        logic [4:0] zero;
        logic       clr_pending;
        logic       sync_pending;
    } wwdt_status_t;

    typedef enum logic [2:0] {
        WD_OFF,
        WD_NORMAL,
        WD_ARMED,
        WD_CLOSED,
        WD_OPEN
    } wwdt_state_t;

    // ticks of one period for a selection code; reserved codes saturate at the longest
    function automatic logic [CNT_W-1:0] wwdt_limit(input logic [3:0] code);
        logic [3:0] c;
        c = (code > CODE_MAX) ? CODE_MAX : code;
        wwdt_limit = CNT_W'(1) << (c + TICK_SHIFT);
    endfunction

    // state entered when a configuration takes effect
    function automatic wwdt_state_t wwdt_entry(input wwdt_ctrl_t cfg);
        if (cfg.period == CODE_OFF)
            wwdt_entry = WD_OFF;
        else if (cfg.window != CODE_OFF)
            wwdt_entry = WD_ARMED;
        else
            wwdt_entry = WD_NORMAL;
    endfunction

endpackage

// ---- test/tb_windowed_watchdog_timer.sv ----
// self-checking bench for the windowed watchdog timer
`timescale 1ns/100ps
module tb_windowed_watchdog_timer
    import wwdt_pkg::*;
();
    logic              mclk;
    logic              rstn;
    logic              osc;
    logic [REG_AW-1:0] addr;
    logic [REG_DW-1:0] wdata;
    logic              wr;
    logic              rd;
    logic [REG_DW-1:0] rdata;
    logic              clr;
    logic              key;
    logic [REG_DW-1:0] fuse;
    logic              rreq;
    int unsigned       rcnt;
    int                num_errors = 0;
    int                compares = 0;
    int                cyc = 0;
    logic [15:0]       lfsr;
    logic [REG_DW-1:0] v;
    int                n;
    int                c0;

    // two oscillator edges per tick keeps the run short
    wwdt_top #(.OSC_EDGES_PER_TICK(2)) wwdt_top_i (
        .mclk_in                      (mclk),
        .rstn_in                      (rstn),
        .ultra_low_power_osc_in       (osc),
        .reg_addr_in                  (addr),
        .reg_wdata_in                 (wdata),
        .reg_wr_in                    (wr),
        .reg_rd_in                    (rd),
        .reg_rdata_out                (rdata),
        .watchdog_clear_instruction_in(clr),
        .config_change_guard_in       (key),
        .fuse_ctrl_in                 (fuse),
        .reset_req_out                (rreq)
    );
    wwdt_peer wwdt_peer_i (
        .mclk_in      (mclk),
        .rstn_in      (rstn),
        .reset_req_in (rreq),
        .osc_out      (osc),
        .rst_count_out(rcnt)
    );

    // 125 MHz system clock
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // hang guard, well above the longest expected run
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors = num_errors + 1;
            results();
        end
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // ticks of one period; a tick is about 30.65 system cycles here
    function automatic int ticks(input int code);
        return 1 << (code + 2);
    endfunction
    // cycle bounds for t ticks, wide enough for oscillator jitter and polling
    function automatic int tlo(input int t);
        return t * 30 - 12;
    endfunction
    function automatic int thi(input int t);
        return t * 31 + 12;
    endfunction

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        compares++;
        if (got < lo || got > hi)
        begin
            num_errors++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
        end
    endtask
    // register write, optionally preceded by the unlock key
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic unlock);
        if (unlock)
        begin
            @(posedge mclk);
            key <= 1'b1;
        end
        @(posedge mclk);
        key   <= 1'b0;
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic pulse_clr();
        @(posedge mclk);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
    endtask
    // poll status until masked bits drop; t counts cycles spent
    task automatic wait_idle(input logic [7:0] m, output int t);
        logic [7:0] s;
        s = m;
        t = 0;
        while ((s & m) !== 8'h00 && t < 400)
        begin
            rd_reg(REG_STATUS_ADDR, s);
            t = t + 2;
        end
    endtask
    // a run past lim returns lim + 1, so a missing request always fails its range
    task automatic wait_req(input int lim, output int t);
        t = 0;
        while (rreq !== 1'b1 && t <= lim)
        begin
            @(posedge mclk);
            #1;
            t = t + 1;
        end
        @(posedge mclk);
        #1;
    endtask
    task automatic results();
        $display("compares %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        lfsr = 16'h28fb;
        {rstn, addr, wdata, wr, rd, clr, key, fuse} = '0;
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        repeat (2) @(posedge mclk);
        // blank fuse: disabled, writes without a live key are dropped
        rd_reg(REG_CTRL_ADDR, v);
        chk("ctrl at reset", 8'h00, v);
        rd_reg(REG_STATUS_ADDR, v);
        chk("status at reset", 8'h00, v);
        lfsr = lfsr_next(lfsr);
        rd_reg(lfsr[7:0] | 8'h02, v);
        chk("unmapped read", 8'h00, v);
        wr_reg(REG_CTRL_ADDR, lfsr[15:8] | 8'h01, 1'b0);
        @(posedge mclk);
        key <= 1'b1;
        @(posedge mclk);
        key <= 1'b0;
        repeat (5) @(posedge mclk);
        wr_reg(REG_CTRL_ADDR, 8'h01, 1'b0);
        rd_reg(REG_CTRL_ADDR, v);
        chk("ctrl after refused writes", 8'h00, v);
        repeat (400) @(posedge mclk);
        chk_rng("requests while disabled", 0, 0, rcnt);
        $display("test disabled done");
        // normal mode: expiry after the selected ticks, then a fresh period
        for (int code = 1; code <= 2; code++)
        begin
            c0 = rcnt;
            wr_reg(REG_CTRL_ADDR, 8'(code), 1'b1);
            wr_reg(REG_CTRL_ADDR, 8'h0f, 1'b1);
            rd_reg(REG_CTRL_ADDR, v);
            chk("ctrl before crossing", 8'(code - 1), v);
            rd_reg(REG_STATUS_ADDR, v);
            chk("sync pending", 8'h01, v);
            wait_idle(8'h01, n);
            rd_reg(REG_CTRL_ADDR, v);
            chk("ctrl applied", 8'(code), v);
            wait_req(thi(ticks(code)), n);
            chk_rng("first expiry", tlo(ticks(code)), thi(ticks(code)), n);
            wait_req(thi(ticks(code)), n);
            chk_rng("second expiry", tlo(ticks(code)), thi(ticks(code)), n);
            chk_rng("requests issued", c0 + 2, c0 + 2, rcnt);
        end
        $display("test normal done");
        // regular clears hold off the 16-tick timeout
        c0 = rcnt;
        repeat (8)
        begin
            pulse_clr();
            pulse_clr();
            rd_reg(REG_STATUS_ADDR, v);
            chk("clear pending", 8'h02, v);
            wait_idle(8'h02, n);
            chk_rng("clear crossing", 44, 101, n);
            lfsr = lfsr_next(lfsr);
            repeat ((4 + lfsr[2:0] % 5) * 31) @(posedge mclk);
        end
        chk_rng("requests with clears", c0, c0, rcnt);
        $display("test clears done");
        // window mode: 8 closed ticks, 16 open ticks
        wr_reg(REG_CTRL_ADDR, 8'h12, 1'b1);
        wait_idle(8'h01, n);
        repeat (6 * 31) @(posedge mclk);
        c0 = rcnt;
        pulse_clr();
        wait_idle(8'h02, n);
        pulse_clr();
        wait_req(thi(6), n);
        chk_rng("early clear", tlo(2), thi(5), n);
        chk_rng("early requests", c0 + 1, c0 + 1, rcnt);
        pulse_clr();
        wait_idle(8'h02, n);
        repeat (10 * 31) @(posedge mclk);
        pulse_clr();
        wait_idle(8'h02, n);
        chk_rng("clear in open slot", c0 + 1, c0 + 1, rcnt);
        wait_req(thi(24), n);
        chk_rng("late expiry", tlo(24), thi(24), n);
        $display("test window done");
        // lock is set-only and freezes the control register
        wr_reg(REG_STATUS_ADDR, 8'h80, 1'b0);
        rd_reg(REG_STATUS_ADDR, v);
        chk("lock without key", 8'h00, v);
        wr_reg(REG_STATUS_ADDR, 8'h80, 1'b1);
        wr_reg(REG_CTRL_ADDR, 8'h00, 1'b1);
        wr_reg(REG_STATUS_ADDR, 8'h00, 1'b1);
        rd_reg(REG_STATUS_ADDR, v);
        chk("lock held", 8'h80, v);
        rd_reg(REG_CTRL_ADDR, v);
        chk("ctrl frozen", 8'h12, v);
        $display("test lock done");
        // fuse configuration enables at boot and sets the lock; drive on an edge
        @(posedge mclk);
        fuse <= 8'h01;
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rd_reg(REG_CTRL_ADDR, v);
        chk("ctrl from fuse", 8'h01, v);
        rd_reg(REG_STATUS_ADDR, v);
        chk("lock from fuse", 8'h80, v);
        wait_req(thi(8), n);
        chk_rng("fuse expiry", tlo(8), thi(8), n);
        $display("test fuse done");
        results();
    end
endmodule // tb_windowed_watchdog_timer

// ---- test/wwdt_peer.sv ----
// partner model: slow oscillator source and system reset controller
`timescale 1ns/100ps
module wwdt_peer
#(
    parameter real HALF_NS = 61.3
)
(
    // clock and reset
    input  wire logic   mclk_in,
    input  wire logic   rstn_in,
    // reset request from the watchdog
    input  wire logic   reset_req_in,
    // oscillator level and request tally
    output logic        osc_out,
    output int unsigned rst_count_out
);
    // free-running oscillator; odd half period keeps its phase unrelated to mclk
    initial
    begin
        osc_out = 1'b0;
        forever #(HALF_NS) osc_out = ~osc_out;
    end
    // reset controller takes each one-cycle request as one system reset
    always_ff @(posedge mclk_in)
    begin
        if (!rstn_in)
            rst_count_out <= 0;
        else if (reset_req_in)
            rst_count_out <= rst_count_out + 1;
    end
endmodule // wwdt_peer
